// File: verilog/reset_wake_register_init.sv
// Reset and wake register initialiser with a Wishbone register slave.
// Assumes reset-kind and wake inputs are one-cycle pulses synchronous to clk_i.
// Functional notes
// - Unimplemented bits read zero; retained bits keep value
// - Interrupt wake sets a source flag bit
// - Enabled interrupt wake loads vector 0008h/0018h
// - Enabled interrupt wake pushes PC, advances stack pointer unless the stack is full
// - Port A bits 6,7 exist per oscillator mode
// - Port E bit 3 usable only without reset pin
//
// Decided for this implementation: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module reset_wake_register_init
  import rwi_pkg::*;
#(
  parameter int STACK_DEPTH = 31
) (
  input wire logic clk_i, // Core clock, 10 MHz
  input wire logic rst_i, // Synchronous reset, active high
  input wire logic wb_cyc_i, // Wishbone cycle
  input wire logic wb_stb_i, // Wishbone strobe
  input wire logic wb_we_i, // Wishbone write enable
  input wire logic [7:0] wb_adr_i, // Wishbone byte address
  input wire logic [3:0] wb_sel_i, // Wishbone byte selects
  input wire logic [31:0] wb_dat_i, // Wishbone write data
  output logic [31:0] wb_dat_o, // Wishbone read data
  output logic wb_ack_o, // Wishbone acknowledge
  input wire logic por_bor_i, // Power-on or brown-out reset pulse
  input wire logic pin_rst_i, // External reset pin pulse
  input wire logic wdt_rst_i, // Watchdog reset pulse
  input wire logic instr_rst_i, // Reset instruction pulse
  input wire logic stack_rst_i, // Stack over/underflow reset pulse
  input wire logic wake_wdt_i, // Wake-up by watchdog pulse
  input wire logic wake_irq_i, // Wake-up by interrupt pulse
  input wire logic wake_high_prio_i, // Wake interrupt is high priority
  input wire logic [3:0] wake_src_i, // Wake source: bit3 set selects PIR bit
  input wire logic [7:0] port_a_pins_i, // Port A pin levels
  output logic [7:0] port_a_out_o, // Port A output data
  output logic [7:0] port_a_oe_o, // Port A output enables
  input wire logic [3:0] port_e_pins_i, // Port E pin levels
  output logic [3:0] port_e_out_o, // Port E output data
  output logic [2:0] port_e_oe_o, // Port E output enables
  output logic [PC_W-1:0] pc_o, // Program counter
  output logic irq_o // Level interrupt, unmasked status set
);
  initial begin
    if (STACK_DEPTH < 2 || STACK_DEPTH > 31) begin
      $error("reset_wake_register_init: STACK_DEPTH must be 2..31");
    end
  end

  localparam logic [SP_W-1:0] SP_LAST = SP_W'(STACK_DEPTH);

  // Address hit, used by read and write decode
  function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
    hit = (adr[7:2] == ofs[7:2]);
  endfunction

  // Merge write data into a register value under byte selects
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    merge = res;
  endfunction

  stack_mem_if #(.AW(SP_W), .DW(PC_W)) smem ();
  stack_mem #(.DEPTH(STACK_DEPTH), .AW(SP_W), .DW(PC_W)) u_stack (
    .clk_i(clk_i),
    .port(smem.mem)
  );

  logic [1:0] cfg_r, cfg_nxt;
  logic [7:0] pa_lat_r, pa_lat_nxt;
  logic [7:0] pa_dir_r, pa_dir_nxt;
  logic [3:0] pe_lat_r, pe_lat_nxt;
  logic [2:0] pe_dir_r, pe_dir_nxt;
  logic [2:0] ictl_flag_r, ictl_flag_nxt;
  logic high_prio_global_irq_enable_r, high_prio_global_irq_enable_nxt, low_prio_global_irq_enable_r, low_prio_global_irq_enable_nxt;
  logic [7:0] pir_r, pir_nxt;
  logic [PC_W-1:0] pc_r, pc_nxt;
  logic [PC_W-1:0] tos_r, tos_nxt;
  logic [SP_W-1:0] sp_r, sp_nxt;
  logic stk_full_r, stk_full_nxt;
  logic [EV_W-1:0] status_r, status_nxt;
  logic [EV_W-1:0] mask_r, mask_nxt;
  logic [SP_W-1:0] view_r, view_nxt;
  logic [PC_W-1:0] vec_r, vec_nxt;
  wake_state_t state_r, state_nxt;
  logic ack_r, ack_nxt;
  logic [31:0] rdat_r, rdat_nxt;

  logic any_reset, req, wr_fire, vec_take;
  logic [7:0] pa_impl;
  logic [3:0] pe_impl;
  logic [31:0] wd;

  // Implemented-bit masks from configuration
  assign pa_impl = cfg_r[CFG_RA67_EN] ? 8'hFF : ~PA_HI_MASK;
  assign pe_impl = cfg_r[CFG_EXT_RST_OFF] ? 4'hF : ~PE_B3_MASK;
  assign any_reset = por_bor_i | pin_rst_i | wdt_rst_i | instr_rst_i | stack_rst_i;
  assign req = wb_cyc_i & wb_stb_i;
  assign wr_fire = req & wb_we_i & ack_r;
  assign vec_take = wake_irq_i & (wake_high_prio_i ? high_prio_global_irq_enable_r : low_prio_global_irq_enable_r);

  // Bus handshake and registered read data
  always_comb begin
    ack_nxt = req & ~ack_r;
    rdat_nxt = rdat_r;
    if (req & ~ack_r) begin
      rdat_nxt = 32'h00000000;
      if (hit(wb_adr_i, OFS_CFG)) begin
        rdat_nxt[1:0] = cfg_r;
      end else if (hit(wb_adr_i, OFS_PA_LAT)) begin
        rdat_nxt[7:0] = pa_lat_r & pa_impl;
      end else if (hit(wb_adr_i, OFS_PA_DIR)) begin
        rdat_nxt[7:0] = pa_dir_r & pa_impl;
      end else if (hit(wb_adr_i, OFS_PA_PIN)) begin
        rdat_nxt[7:0] = port_a_pins_i & pa_impl;
      end else if (hit(wb_adr_i, OFS_PE_LAT)) begin
        rdat_nxt[3:0] = pe_lat_r & pe_impl;
      end else if (hit(wb_adr_i, OFS_PE_DIR)) begin
        rdat_nxt[2:0] = pe_dir_r;
      end else if (hit(wb_adr_i, OFS_PE_PIN)) begin
        rdat_nxt[3:0] = port_e_pins_i & pe_impl;
      end else if (hit(wb_adr_i, OFS_INTCTL)) begin
        rdat_nxt[7:0] = {high_prio_global_irq_enable_r, low_prio_global_irq_enable_r, 3'h0, ictl_flag_r};
      end else if (hit(wb_adr_i, OFS_PIR)) begin
        rdat_nxt[7:0] = pir_r;
      end else if (hit(wb_adr_i, OFS_PC)) begin
        rdat_nxt[PC_W-1:0] = pc_r;
      end else if (hit(wb_adr_i, OFS_TOS)) begin
        rdat_nxt[PC_W-1:0] = tos_r;
      end else if (hit(wb_adr_i, OFS_HW_STACK_POINTER)) begin
        rdat_nxt[7:0] = {stk_full_r, 2'h0, sp_r};
      end else if (hit(wb_adr_i, OFS_STATUS)) begin
        rdat_nxt[EV_W-1:0] = status_r;
      end else if (hit(wb_adr_i, OFS_MASK)) begin
        rdat_nxt[EV_W-1:0] = mask_r;
      end else if (hit(wb_adr_i, OFS_STKVIEW)) begin
        rdat_nxt[PC_W-1:0] = smem.rdata;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      rdat_r <= 32'h00000000;
    end else begin
      ack_r <= ack_nxt;
      rdat_r <= rdat_nxt;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;

  // Register state: bus writes first, then reset kinds and wake events override
  always_comb begin
    wd = 32'h00000000;
    cfg_nxt = cfg_r;
    pa_lat_nxt = pa_lat_r;
    pa_dir_nxt = pa_dir_r;
    pe_lat_nxt = pe_lat_r;
    pe_dir_nxt = pe_dir_r;
    ictl_flag_nxt = ictl_flag_r;
    high_prio_global_irq_enable_nxt = high_prio_global_irq_enable_r;
    low_prio_global_irq_enable_nxt = low_prio_global_irq_enable_r;
    pir_nxt = pir_r;
    mask_nxt = mask_r;
    view_nxt = view_r;
    status_nxt = status_r;
    if (wr_fire) begin
      if (hit(wb_adr_i, OFS_CFG)) begin
        wd = merge({30'h0, cfg_r}, wb_dat_i, wb_sel_i);
        cfg_nxt = wd[1:0];
      end else if (hit(wb_adr_i, OFS_PA_LAT)) begin
        wd = merge({24'h0, pa_lat_r}, wb_dat_i, wb_sel_i);
        pa_lat_nxt = wd[7:0] & pa_impl;
      end else if (hit(wb_adr_i, OFS_PA_DIR)) begin
        wd = merge({24'h0, pa_dir_r}, wb_dat_i, wb_sel_i);
        pa_dir_nxt = (wd[7:0] & pa_impl) | (pa_dir_r & ~pa_impl);
      end else if (hit(wb_adr_i, OFS_PE_LAT)) begin
        wd = merge({28'h0, pe_lat_r}, wb_dat_i, wb_sel_i);
        pe_lat_nxt = wd[3:0] & pe_impl;
      end else if (hit(wb_adr_i, OFS_PE_DIR)) begin
        wd = merge({29'h0, pe_dir_r}, wb_dat_i, wb_sel_i);
        pe_dir_nxt = wd[2:0];
      end else if (hit(wb_adr_i, OFS_INTCTL)) begin
        wd = merge({24'h0, high_prio_global_irq_enable_r, low_prio_global_irq_enable_r, 3'h0, ictl_flag_r}, wb_dat_i, wb_sel_i);
        high_prio_global_irq_enable_nxt = wd[ICTL_HIGH_PRIO_GLOBAL_IRQ_ENABLE];
        low_prio_global_irq_enable_nxt = wd[ICTL_LOW_PRIO_GLOBAL_IRQ_ENABLE];
        ictl_flag_nxt = wd[2:0] & ICTL_FLAG_MASK;
      end else if (hit(wb_adr_i, OFS_PIR)) begin
        wd = merge({24'h0, pir_r}, wb_dat_i, wb_sel_i);
        pir_nxt = wd[7:0];
      end else if (hit(wb_adr_i, OFS_STATUS)) begin
        wd = merge(32'h0, wb_dat_i, wb_sel_i);
        status_nxt = status_r & ~wd[EV_W-1:0];
      end else if (hit(wb_adr_i, OFS_MASK)) begin
        wd = merge({24'h0, mask_r}, wb_dat_i, wb_sel_i);
        mask_nxt = wd[EV_W-1:0];
      end else if (hit(wb_adr_i, OFS_STKVIEW)) begin
        wd = merge({27'h0, view_r}, wb_dat_i, wb_sel_i);
        view_nxt = wd[SP_W-1:0];
      end
    end
    // Resets force directions to input; latches survive except on power-on
    if (any_reset) begin
      pa_dir_nxt = PA_DIR_RST;
      pe_dir_nxt = PE_DIR_RST;
      ictl_flag_nxt = 3'h0;
      high_prio_global_irq_enable_nxt = 1'b0;
      low_prio_global_irq_enable_nxt = 1'b0;
      pir_nxt = 8'h00;
      if (por_bor_i) begin
        pa_lat_nxt = 8'h00;
        pe_lat_nxt = 4'h0;
      end
    end else if (wake_irq_i) begin
      // Flag the wake source; everything else is kept
      if (wake_src_i[3]) begin
        pir_nxt[wake_src_i[2:0]] = 1'b1;
      end else if (wake_src_i[1:0] == 2'h3) begin
        ictl_flag_nxt[2] = 1'b1;
      end else begin
        ictl_flag_nxt[wake_src_i[1:0]] = 1'b1;
      end
    end
    // Hardware events set status after any clear, so the set wins
    status_nxt[EV_POR] = status_nxt[EV_POR] | por_bor_i;
    status_nxt[EV_PIN] = status_nxt[EV_PIN] | pin_rst_i;
    status_nxt[EV_WDT] = status_nxt[EV_WDT] | wdt_rst_i;
    status_nxt[EV_INSTR] = status_nxt[EV_INSTR] | instr_rst_i;
    status_nxt[EV_STACK] = status_nxt[EV_STACK] | stack_rst_i;
    status_nxt[EV_WAKE_WDT] = status_nxt[EV_WAKE_WDT] | wake_wdt_i;
    status_nxt[EV_WAKE_IRQ] = status_nxt[EV_WAKE_IRQ] | wake_irq_i;
    status_nxt[EV_PUSH_LOST] = status_nxt[EV_PUSH_LOST] | (state_r == ST_PUSH && stk_full_r);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_r <= CFG_RST;
      pa_lat_r <= 8'h00;
      pa_dir_r <= PA_DIR_RST;
      pe_lat_r <= 4'h0;
      pe_dir_r <= PE_DIR_RST;
      ictl_flag_r <= 3'h0;
      high_prio_global_irq_enable_r <= 1'b0;
      low_prio_global_irq_enable_r <= 1'b0;
      pir_r <= 8'h00;
      status_r <= '0;
      mask_r <= MASK_RST;
      view_r <= '0;
    end else begin
      cfg_r <= cfg_nxt;
      pa_lat_r <= pa_lat_nxt;
      pa_dir_r <= pa_dir_nxt;
      pe_lat_r <= pe_lat_nxt;
      pe_dir_r <= pe_dir_nxt;
      ictl_flag_r <= ictl_flag_nxt;
      high_prio_global_irq_enable_r <= high_prio_global_irq_enable_nxt;
      low_prio_global_irq_enable_r <= low_prio_global_irq_enable_nxt;
      pir_r <= pir_nxt;
      status_r <= status_nxt;
      mask_r <= mask_nxt;
      view_r <= view_nxt;
    end
  end

  // Wake sequencer: push return address, then load the vector
  always_comb begin
    state_nxt = state_r;
    pc_nxt = pc_r;
    tos_nxt = tos_r;
    sp_nxt = sp_r;
    stk_full_nxt = stk_full_r;
    vec_nxt = vec_r;
    smem.we = 1'b0;
    smem.waddr = sp_r;
    smem.wdata = pc_r;
    smem.raddr = view_r;
    if (wr_fire && hit(wb_adr_i, OFS_PC)) begin
      pc_nxt = wb_dat_i[PC_W-1:0];
    end
    case (state_r)
      ST_IDLE: begin
        if (!any_reset && vec_take) begin
          vec_nxt = wake_high_prio_i ? VEC_HIGH : VEC_LOW;
          state_nxt = ST_PUSH;
        end
      end
      ST_PUSH: begin
        if (!stk_full_r) begin
          smem.we = 1'b1;
          tos_nxt = pc_r;
          sp_nxt = sp_r + SP_W'(1);
          stk_full_nxt = (sp_r + SP_W'(1)) == SP_LAST;
        end
        state_nxt = ST_LOAD;
      end
      ST_LOAD: begin
        pc_nxt = vec_r;
        state_nxt = ST_IDLE;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
    // Any reset kind restarts the core and empties the stack
    if (any_reset) begin
      state_nxt = ST_IDLE;
      pc_nxt = '0;
      sp_nxt = '0;
      stk_full_nxt = 1'b0;
      tos_nxt = '0;
      smem.we = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= ST_IDLE;
      pc_r <= '0;
      tos_r <= '0;
      sp_r <= '0;
      stk_full_r <= 1'b0;
      vec_r <= '0;
    end else begin
      state_r <= state_nxt;
      pc_r <= pc_nxt;
      tos_r <= tos_nxt;
      sp_r <= sp_nxt;
      stk_full_r <= stk_full_nxt;
      vec_r <= vec_nxt;
    end
  end

  // Pin drivers: disabled bits neither drive nor carry data
  assign port_a_out_o = pa_lat_r & pa_impl;
  assign port_a_oe_o = ~pa_dir_r & pa_impl;
  assign port_e_out_o = pe_lat_r & pe_impl;
  assign port_e_oe_o = ~pe_dir_r;
  assign pc_o = pc_r;
  assign irq_o = |(status_r & mask_r);

  // Checks
  a_dir_on_reset: assert property (@(posedge clk_i) disable iff (rst_i)
    any_reset |=> (pa_dir_r == PA_DIR_RST) && (pe_dir_r == PE_DIR_RST))
    else $error("direction not set to input after reset");
  a_dir_on_wake: assert property (@(posedge clk_i) disable iff (rst_i)
    (wake_irq_i || wake_wdt_i) && !any_reset && !wr_fire |=> $stable(pa_dir_r))
    else $error("direction changed on wake");
  a_wake_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    wake_irq_i && !any_reset |=> (|pir_r) || (|ictl_flag_r))
    else $error("interrupt wake left no flag");
  a_vector_load: assert property (@(posedge clk_i) disable iff (rst_i)
    state_r == ST_IDLE && vec_take && !any_reset && wake_high_prio_i
    ##1 !any_reset [*2] |=> pc_r == VEC_HIGH)
    else $error("high vector not loaded");
  a_push_tos: assert property (@(posedge clk_i) disable iff (rst_i)
    state_r == ST_PUSH && !stk_full_r && !any_reset |=> tos_r == $past(pc_r) && sp_r == $past(sp_r) + SP_W'(1))
    else $error("return address not pushed");
  a_pa_hi_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    !cfg_r[CFG_RA67_EN] |-> (port_a_out_o & PA_HI_MASK) == 8'h00 && (port_a_oe_o & PA_HI_MASK) == 8'h00)
    else $error("port A high bits active while disabled");
  a_pe_b3_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    !cfg_r[CFG_EXT_RST_OFF] |-> !port_e_out_o[3])
    else $error("port E bit 3 active while reset pin used");
  a_unimpl_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_r && hit($past(wb_adr_i), OFS_HW_STACK_POINTER) |-> wb_dat_o[6:5] == 2'h0 && wb_dat_o[31:8] == 24'h0)
    else $error("unimplemented bits read nonzero");
  a_lat_retained: assert property (@(posedge clk_i) disable iff (rst_i)
    (pin_rst_i || wdt_rst_i) && !por_bor_i && !wr_fire |=> $stable(pa_lat_r))
    else $error("latch lost across reset");

  c_irq_wake: cover property (@(posedge clk_i) disable iff (rst_i) state_r == ST_LOAD);
  c_wdt_wake: cover property (@(posedge clk_i) disable iff (rst_i) wake_wdt_i ##1 irq_o);
  c_por: cover property (@(posedge clk_i) disable iff (rst_i) por_bor_i);
  c_stack_full: cover property (@(posedge clk_i) disable iff (rst_i) stk_full_r);
endmodule
`default_nettype wire

// File: pkg/rwi_pkg.sv
// Package: constants shared by the reset and wake register block.
// Assumes a 32-bit classic Wishbone bus with word-aligned byte addresses.
package rwi_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CFG = 8'h00;
  localparam logic [7:0] OFS_PA_LAT = 8'h04;
  localparam logic [7:0] OFS_PA_DIR = 8'h08;
  localparam logic [7:0] OFS_PA_PIN = 8'h0C;
  localparam logic [7:0] OFS_PE_LAT = 8'h10;
  localparam logic [7:0] OFS_PE_DIR = 8'h14;
  localparam logic [7:0] OFS_PE_PIN = 8'h18;
  localparam logic [7:0] OFS_INTCTL = 8'h1C;
  localparam logic [7:0] OFS_PIR = 8'h20;
  localparam logic [7:0] OFS_PC = 8'h24;
  localparam logic [7:0] OFS_TOS = 8'h28;
  localparam logic [7:0] OFS_HW_STACK_POINTER = 8'h2C;
  localparam logic [7:0] OFS_STATUS = 8'h30;
  localparam logic [7:0] OFS_MASK = 8'h34;
  localparam logic [7:0] OFS_STKVIEW = 8'h38;
  // Field positions
  localparam int CFG_RA67_EN = 0;
  localparam int CFG_EXT_RST_OFF = 1;
  localparam int ICTL_HIGH_PRIO_GLOBAL_IRQ_ENABLE = 7;
  localparam int ICTL_LOW_PRIO_GLOBAL_IRQ_ENABLE = 6;
  localparam int STK_FULL = 7;
  localparam int EV_POR = 0;
  localparam int EV_PIN = 1;
  localparam int EV_WDT = 2;
  localparam int EV_INSTR = 3;
  localparam int EV_STACK = 4;
  localparam int EV_WAKE_WDT = 5;
  localparam int EV_WAKE_IRQ = 6;
  localparam int EV_PUSH_LOST = 7;
  localparam int EV_W = 8;
  // Widths and masks
  localparam int PC_W = 21;
  localparam int SP_W = 5;
  localparam logic [7:0] PA_HI_MASK = 8'hC0;
  localparam logic [3:0] PE_B3_MASK = 4'h8;
  localparam logic [2:0] ICTL_FLAG_MASK = 3'h7;
  // Reset values
  localparam logic [7:0] PA_DIR_RST = 8'hFF;
  localparam logic [2:0] PE_DIR_RST = 3'h7;
  localparam logic [1:0] CFG_RST = 2'h0;
  localparam logic [EV_W-1:0] MASK_RST = 8'h00;
  // Interrupt vectors
  localparam logic [PC_W-1:0] VEC_HIGH = 21'h000008;
  localparam logic [PC_W-1:0] VEC_LOW = 21'h000018;
  // Wake sequencer states, Gray coded along idle, push, load
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_PUSH = 2'b01,
    ST_LOAD = 2'b11
  } wake_state_t;
endpackage

// File: pkg/stack_mem_if.sv
// Interface: write and read port of the return-address stack memory.
// Assumes one clock shared by owner and memory.
`timescale 1ns/1ps
`default_nettype none
interface stack_mem_if #(
  parameter int AW = 5,
  parameter int DW = 21
);
  logic we;
  logic [AW-1:0] waddr;
  logic [DW-1:0] wdata;
  logic [AW-1:0] raddr;
  logic [DW-1:0] rdata;
  modport owner (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface
`default_nettype wire

// File: verilog/stack_mem.sv
// Stack memory: return addresses pushed on interrupt wake-up.
// Assumes synchronous clock; read data is registered one cycle after raddr.
`timescale 1ns/1ps
`default_nettype none
module stack_mem #(
  parameter int DEPTH = 31,
  parameter int AW = 5,
  parameter int DW = 21
) (
  input wire logic clk_i, // Core clock
  stack_mem_if.mem port // Memory port
);
  logic [DW-1:0] mem_r [DEPTH];
  logic [DW-1:0] rdata_r;

  initial begin
    if (DEPTH < 2 || DEPTH > (1 << AW)) begin
      $error("stack_mem: DEPTH does not fit the address width");
    end
  end

  // Write port and registered read port
  always_ff @(posedge clk_i) begin
    if (port.we && (32'(port.waddr) < DEPTH)) begin
      mem_r[port.waddr] <= port.wdata;
    end
    rdata_r <= (32'(port.raddr) < DEPTH) ? mem_r[port.raddr] : '0;
  end

  assign port.rdata = rdata_r;
endmodule
`default_nettype wire

// File: verification/reset_wake_register_init_bench.sv
// Self-checking bench for the reset and wake register block.
// Assumes the package and design files are compiled first; the bench drives every port itself.
`timescale 1ns/1ps
`default_nettype none
module reset_wake_register_init_bench;
  import rwi_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic irq_o;
  logic [6:0] ev = 7'h00; // Reset kinds 0..4, watchdog wake 5, interrupt wake 6
  logic hp = 1'b0;
  logic [3:0] src = 4'h0;
  logic [7:0] pa_pins = 8'h00;
  logic [3:0] pe_pins = 4'h0;
  logic [7:0] pa_out;
  logic [7:0] pa_oe;
  logic [3:0] pe_out;
  logic [2:0] pe_oe;
  logic [PC_W-1:0] pc_o;
  logic [31:0] seed = 32'h00000032;
  logic [31:0] exp_q[$];
  int fail_count = 0;
  int checked = 0;

  // Clock at 10 MHz
  initial begin
    forever #50 clk_i = ~clk_i;
  end

  reset_wake_register_init dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .por_bor_i(ev[0]), .pin_rst_i(ev[1]), .wdt_rst_i(ev[2]), .instr_rst_i(ev[3]), .stack_rst_i(ev[4]),
    .wake_wdt_i(ev[5]), .wake_irq_i(ev[6]), .wake_high_prio_i(hp), .wake_src_i(src),
    .port_a_pins_i(pa_pins), .port_a_out_o(pa_out), .port_a_oe_o(pa_oe), .port_e_pins_i(pe_pins),
    .port_e_out_o(pe_out), .port_e_oe_o(pe_oe), .pc_o(pc_o), .irq_o(irq_o)
  );

  // Next value of the xorshift sequence
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  // Compares one value and counts it
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Prints the counts and the verdict, then stops
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // One classic Wishbone cycle, held until ack is sampled, then one idle cycle
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hF;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (wb_ack_o !== 1'b1) begin
      fail_count++;
      finish_test();
    end
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask

  // Notes the expected read data, then runs the read
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    wb(1'b0, a, 32'h0);
  endtask

  // One-cycle event pulse on the chosen input
  task automatic pulse(input int b);
    ev[b] <= 1'b1;
    @(posedge clk_i);
    ev <= 7'h00;
    @(posedge clk_i);
  endtask

  // Checks settled outputs mid-cycle, then returns on a rising edge
  task automatic outs(input logic [PC_W-1:0] pc, input logic irq, input logic [7:0] ao, input logic [7:0] ae);
    @(negedge clk_i);
    check({11'h0, pc_o}, {11'h0, pc});
    check({31'h0, irq_o}, {31'h0, irq});
    check({24'h0, pa_out}, {24'h0, ao});
    check({24'h0, pa_oe}, {24'h0, ae});
    @(posedge clk_i);
  endtask

  // Checks the port E outputs mid-cycle, then returns on a rising edge
  task automatic eouts(input logic [3:0] eo, input logic [2:0] ee);
    @(negedge clk_i);
    check({28'h0, pe_out}, {28'h0, eo});
    check({29'h0, pe_oe}, {29'h0, ee});
    @(posedge clk_i);
  endtask

  // Read data watcher: takes the oldest note at every read acknowledge
  always @(posedge clk_i) begin
    if (wb_ack_o === 1'b1 && wb_cyc_i && !wb_we_i) begin
      if (exp_q.size() == 0) begin
        fail_count++;
      end else begin
        check(wb_dat_o, exp_q.pop_front());
      end
    end
  end

  // Main sequence
  initial begin
    int c;
    int b;
    logic [7:0] am;
    logic [3:0] em;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    outs(21'h0, 1'b0, 8'h00, 8'h00);
    wr(OFS_STATUS, 32'hFF);
    rd(OFS_STATUS, 32'h0);
    rd(OFS_CFG, 32'h0);
    rd(OFS_PA_DIR, 32'h3F);
    rd(OFS_PE_DIR, 32'h7);
    wr(OFS_PA_DIR, 32'h0);
    wr(OFS_PA_LAT, 32'hFF);
    outs(21'h0, 1'b0, 8'h3F, 8'h3F);
    // Every oscillator and reset-pin setting, with random pin levels
    for (c = 0; c < 4; c++) begin
      am = c[0] ? 8'hFF : 8'h3F;
      em = c[1] ? 4'hF : 4'h7;
      seed = xs(seed);
      pa_pins <= seed[7:0];
      pe_pins <= seed[11:8];
      wr(OFS_CFG, c);
      rd(OFS_PA_PIN, {24'h0, seed[7:0] & am});
      rd(OFS_PE_PIN, {28'h0, seed[11:8] & em});
      wr(OFS_PA_LAT, 32'hFF);
      rd(OFS_PA_LAT, {24'h0, am});
      wr(OFS_PE_LAT, 32'hF);
      rd(OFS_PE_LAT, {28'h0, em});
      eouts(em, 3'h0);
    end
    wr(8'h3C, 32'hFFFFFFFF);
    rd(8'h3C, 32'h0);
    wr(OFS_MASK, 32'hFF);
    // Each reset kind: directions to input, latch kept except on power-on
    for (b = 0; b < 5; b++) begin
      wr(OFS_PA_LAT, 32'hA5);
      wr(OFS_PA_DIR, 32'h0);
      wr(OFS_PE_DIR, 32'h0);
      wr(OFS_PE_LAT, 32'hA);
      eouts(4'hA, 3'h7);
      wr(OFS_PC, 32'h1234);
      pulse(b);
      outs(21'h0, 1'b1, (b == 0) ? 8'h00 : 8'hA5, 8'h00);
      eouts((b == 0) ? 4'h0 : 4'hA, 3'h0);
      rd(OFS_PA_DIR, 32'hFF);
      rd(OFS_PE_DIR, 32'h7);
      rd(OFS_STATUS, 32'h1 << b);
      wr(OFS_STATUS, 32'hFF);
      outs(21'h0, 1'b0, (b == 0) ? 8'h00 : 8'hA5, 8'h00);
    end
    // Watchdog wake keeps directions and latches; masked event holds irq low
    wr(OFS_PA_DIR, 32'h0F);
    wr(OFS_MASK, 32'h0);
    pulse(5);
    outs(21'h0, 1'b0, 8'hA5, 8'hF0);
    rd(OFS_STATUS, 32'h20);
    wr(OFS_MASK, 32'h20);
    outs(21'h0, 1'b1, 8'hA5, 8'hF0);
    wr(OFS_STATUS, 32'hFF);
    // Interrupt wake with no global enable: flag only
    wr(OFS_PC, 32'h1234);
    src <= 4'h9;
    pulse(6);
    rd(OFS_PIR, 32'h02);
    rd(OFS_PC, 32'h1234);
    rd(OFS_HW_STACK_POINTER, 32'h0);
    // High priority wake with its enable set
    wr(OFS_INTCTL, 32'h80);
    hp <= 1'b1;
    src <= 4'h3;
    pulse(6);
    repeat (2) @(posedge clk_i);
    outs(21'h000008, 1'b0, 8'hA5, 8'hF0);
    rd(OFS_TOS, 32'h1234);
    rd(OFS_HW_STACK_POINTER, 32'h1);
    rd(OFS_INTCTL, 32'h84);
    // Low priority wake with its enable set
    wr(OFS_PC, 32'hABCD);
    wr(OFS_INTCTL, 32'h40);
    hp <= 1'b0;
    src <= 4'h0;
    pulse(6);
    repeat (2) @(posedge clk_i);
    outs(21'h000018, 1'b0, 8'hA5, 8'hF0);
    rd(OFS_TOS, 32'hABCD);
    rd(OFS_HW_STACK_POINTER, 32'h2);
    rd(OFS_INTCTL, 32'h41);
    wr(OFS_STKVIEW, 32'h0);
    rd(OFS_STKVIEW, 32'h1234);
    finish_test();
  end

  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge clk_i);
    fail_count++;
    finish_test();
  end
endmodule
`default_nettype wire
